/* File: logic/feap_ctrl.v */
// command interpreter for array erase, address mode, upper address byte and sleep
//
// Operation
// - Opcodes C7h and 60h both decode as whole-array erase.
// - Array erase sets all bits to one; needs write enable latch set first.
// - Erase runs only if chip select rises right after the eighth opcode bit.
// - Chip select rise starts timed erase; busy bit high throughout; latch cleared.
// - Erase ignored entirely while any block is write-protected.
// - After reset, address fields are 24 bits until switched.
// - Opcode B7h sets the wide address flag; addresses become 32 bits.
// - Opcode E9h clears the wide address flag; back to 24-bit addresses.
// - In 24-bit mode the upper address byte supplies A31 to A24.
// - Opcode C8h shifts the upper address byte out MSB first on falling edges.
// - Opcode C5h plus a data byte writes upper byte only when latch set.
// - Upper address byte clears to zero at power-up and any reset.
// - In 32-bit mode, address bits A31 to A24 overwrite the upper byte.
// - Only opcode B9h enters sleep; sleep ignores write, program and erase.
// - Sleep ignores all but wake/identify and software reset, which leave it.
// - Chip select high with nothing running means standby, not sleep.
// - Power-up lands in standby; power-down ends sleep.
// - Sleep entered a delay after chip select rises exactly after eighth bit.
// - Sleep opcode during an erase is rejected, erase unaffected.
// - Opcode ABh leaves sleep; commands accepted again after the wake delay.
`timescale 1ns/1ps
`include "feap_consts.vh"
module feap_ctrl #(
   parameter ERASE_CYCLES = `FEAP_ERASE_ALL_MS * `FEAP_SYS_CLK_MHZ * 1000
) (
   // clock and reset
   input  wire       i_sys_clk,
   input  wire       i_resetn,
   // serial link pins from the host
   input  wire       i_spi_clk,
   input  wire       i_spi_cs_n,
   input  wire       i_serial_in,
   // serial output pin
   output wire       o_serial_out,
   output wire       o_serial_out_oe,
   // neighbouring device logic, same clock
   input  wire       i_sw_reset,
   input  wire       i_any_block_protected,
   input  wire       i_addr_top_valid,
   input  wire [7:0] i_addr_top,
   // status and array control
   output wire       o_write_in_progress,
   output wire       o_write_enable_latch,
   output wire       o_wide_address_flag,
   output wire [7:0] o_upper_address,
   output wire [7:0] o_access_addr_hi,
   output wire       o_erase_start,
   output wire [7:0] o_erase_fill,
   output wire       o_deep_sleep,
   output wire       o_cmd_ready
);

   // power states
   localparam [1:0] PM_STANDBY = 2'b00;
   localparam [1:0] PM_ENTER   = 2'b01;
   localparam [1:0] PM_SLEEP   = 2'b10;
   localparam [1:0] PM_WAKE    = 2'b11;

   localparam [`FEAP_TIMER_W-1:0] ERASE_LOAD = ERASE_CYCLES;
   localparam [`FEAP_TIMER_W-1:0] SLEEP_LOAD = `FEAP_SLEEP_ENTRY_CYC;
   localparam [`FEAP_TIMER_W-1:0] WAKE_LOAD  = `FEAP_WAKE_CYC;

   wire       cs_n_s;
   wire       sclk_s;
   wire       si_s;
   reg        sclk_prev_reg;
   reg        cs_prev_reg;
   reg  [4:0] bit_cnt_reg;
   reg  [7:0] shin_reg;
   reg  [7:0] opcode_reg;
   reg  [7:0] shout_reg;
   reg        so_reg;
   reg        oe_reg;
   reg        read_active_reg;
   reg        wel_reg;
   reg        wide_reg;
   reg  [7:0] upper_reg;
   reg  [1:0] pm_reg;
   reg  [1:0] pm_next;
   reg        erase_go;
   reg        pm_load;
   reg  [`FEAP_TIMER_W-1:0] pm_load_val;
   wire       erase_busy;
   wire       erase_done;
   wire       pm_busy;
   wire       pm_done;

   //////////////////////////////////////////////////////////////////////////
   // pin synchronisers; chip select idles high
   feap_sync #(.RESET_VAL(1'b1)) u_sync_cs (
      .i_clk    (i_sys_clk),
      .i_resetn (i_resetn),
      .i_async  (i_spi_cs_n),
      .o_sync   (cs_n_s)
   );

   feap_sync #(.RESET_VAL(1'b0)) u_sync_clk (
      .i_clk    (i_sys_clk),
      .i_resetn (i_resetn),
      .i_async  (i_spi_clk),
      .o_sync   (sclk_s)
   );

   feap_sync #(.RESET_VAL(1'b0)) u_sync_si (
      .i_clk    (i_sys_clk),
      .i_resetn (i_resetn),
      .i_async  (i_serial_in),
      .o_sync   (si_s)
   );

   //////////////////////////////////////////////////////////////////////////
   // edge detection on the synchronised pins
   wire selected  = ~cs_n_s;
   wire sclk_rise = selected & sclk_s & ~sclk_prev_reg;
   wire sclk_fall = selected & ~sclk_s & sclk_prev_reg;
   wire cs_rise   = cs_n_s & ~cs_prev_reg;
   wire cs_fall   = ~cs_n_s & cs_prev_reg;
   wire [7:0] byte_in = {shin_reg[6:0], si_s};

   // a frame ends cleanly only when exactly one opcode byte was latched
   wire frame8    = (bit_cnt_reg == `FEAP_OPCODE_BITS);
   wire opc_done  = sclk_rise & (bit_cnt_reg == `FEAP_OPCODE_LAST);
   wire data_done = sclk_rise & (bit_cnt_reg == `FEAP_DATA_LAST);
   wire standby   = (pm_reg == PM_STANDBY);
   // while erasing, only the upper byte read is serviced
   wire accept    = standby & ~erase_busy;

   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         sclk_prev_reg <= 1'b0;
         cs_prev_reg   <= 1'b1;
      end else begin
         sclk_prev_reg <= sclk_s;
         cs_prev_reg   <= cs_n_s;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // input shifter, bit counter and opcode capture on link rising edges
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         bit_cnt_reg <= 5'h00;
         shin_reg    <= 8'h00;
         opcode_reg  <= 8'h00;
      end else if (cs_fall) begin
         bit_cnt_reg <= 5'h00;
      end else if (sclk_rise) begin
         shin_reg <= byte_in;
         // saturate so long frames never wrap back onto a byte boundary
         if (bit_cnt_reg != `FEAP_BITCNT_MAX) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
         end
         if (opc_done) begin
            opcode_reg <= byte_in;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // upper byte readout: loaded at the eighth rising edge, shifted on falls
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         shout_reg       <= 8'h00;
         so_reg          <= 1'b0;
         oe_reg          <= 1'b0;
         read_active_reg <= 1'b0;
      end else if (!selected) begin
         oe_reg          <= 1'b0;
         read_active_reg <= 1'b0;
      end else if (opc_done && byte_in == `FEAP_OP_UPPER_READ && standby) begin
         shout_reg       <= upper_reg;
         read_active_reg <= 1'b1;
      end else if (sclk_fall && read_active_reg) begin
         // msb first, rotating so a long read repeats the byte
         so_reg    <= shout_reg[7];
         shout_reg <= {shout_reg[6:0], shout_reg[7]};
         oe_reg    <= 1'b1;
      end
   end

   assign o_serial_out    = so_reg;
   assign o_serial_out_oe = oe_reg;

   //////////////////////////////////////////////////////////////////////////
   // write enable latch, array erase start and address mode flag
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         wel_reg  <= 1'b0;
         wide_reg <= 1'b0;
         erase_go <= 1'b0;
      end else begin
         erase_go <= 1'b0;
         if (i_sw_reset) begin
            wel_reg  <= 1'b0;
            wide_reg <= 1'b0;
         end else if (cs_rise && frame8 && accept) begin
            case (opcode_reg)
               `FEAP_OP_WRITE_ENABLE: begin
                  wel_reg <= 1'b1;
               end
               `FEAP_OP_WRITE_DISABLE: begin
                  wel_reg <= 1'b0;
               end
               `FEAP_OP_ERASE_ALL_A, `FEAP_OP_ERASE_ALL_B: begin
                  // protected blocks or no latch: command dropped whole
                  if (wel_reg && !i_any_block_protected) begin
                     erase_go <= 1'b1;
                     wel_reg  <= 1'b0;
                  end
               end
               `FEAP_OP_WIDE_ENTER: begin
                  wide_reg <= 1'b1;
               end
               `FEAP_OP_WIDE_EXIT: begin
                  wide_reg <= 1'b0;
               end
               default: begin
                  wel_reg <= wel_reg;
               end
            endcase
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // upper address byte: cleared by resets, written by command or wide access
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         upper_reg <= `FEAP_UPPER_RESET;
      end else if (i_sw_reset) begin
         upper_reg <= `FEAP_UPPER_RESET;
      end else if (data_done && opcode_reg == `FEAP_OP_UPPER_WRITE
                   && wel_reg && accept) begin
         upper_reg <= byte_in;
      end else if (i_addr_top_valid && wide_reg) begin
         upper_reg <= i_addr_top;
      end
   end

   // upper byte stands in for A31..A24 only in 24-bit mode
   assign o_access_addr_hi = wide_reg ? i_addr_top : upper_reg;

   //////////////////////////////////////////////////////////////////////////
   // self-timed array erase; busy bit follows the timer
   feap_timer #(.W(`FEAP_TIMER_W)) u_erase_timer (
      .i_clk    (i_sys_clk),
      .i_resetn (i_resetn),
      .i_start  (erase_go),
      .i_load   (ERASE_LOAD),
      .i_abort  (i_sw_reset),
      .o_busy   (erase_busy),
      .o_done   (erase_done)
   );

   //////////////////////////////////////////////////////////////////////////
   // power state: standby, entering sleep, asleep, waking
   always @* begin
      pm_next     = pm_reg;
      pm_load     = 1'b0;
      pm_load_val = SLEEP_LOAD;
      case (pm_reg)
         PM_STANDBY: begin
            // sleep refused while an erase runs; erase carries on untouched
            if (cs_rise && frame8 && opcode_reg == `FEAP_OP_SLEEP
                && !erase_busy) begin
               pm_next = PM_ENTER;
               pm_load = 1'b1;
            end
         end
         PM_ENTER: begin
            if (pm_done) begin
               pm_next = PM_SLEEP;
            end
         end
         PM_SLEEP: begin
            // only wake/identify gets through; identify may carry dummies
            if (cs_rise && bit_cnt_reg >= `FEAP_OPCODE_BITS
                && opcode_reg == `FEAP_OP_WAKE_IDENTIFY) begin
               pm_next     = PM_WAKE;
               pm_load     = 1'b1;
               pm_load_val = WAKE_LOAD;
            end
         end
         PM_WAKE: begin
            if (pm_done) begin
               pm_next = PM_STANDBY;
            end
         end
         default: begin
            pm_next = PM_STANDBY;
         end
      endcase
   end

   // reset or software reset lands in standby, never in sleep
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pm_reg <= PM_STANDBY;
      end else if (i_sw_reset) begin
         pm_reg <= PM_STANDBY;
      end else begin
         pm_reg <= pm_next;
      end
   end

   feap_timer #(.W(`FEAP_TIMER_W)) u_pm_timer (
      .i_clk    (i_sys_clk),
      .i_resetn (i_resetn),
      .i_start  (pm_load),
      .i_load   (pm_load_val),
      .i_abort  (i_sw_reset),
      .o_busy   (pm_busy),
      .o_done   (pm_done)
   );

   //////////////////////////////////////////////////////////////////////////
   // status outputs
   assign o_write_in_progress  = erase_busy;
   assign o_write_enable_latch = wel_reg;
   assign o_wide_address_flag  = wide_reg;
   assign o_upper_address      = upper_reg;
   assign o_erase_start        = erase_go;
   assign o_erase_fill         = `FEAP_ERASED_BYTE;
   assign o_deep_sleep         = (pm_reg == PM_SLEEP);
   // ready excludes the entry and wake windows; timer busy only there
   assign o_cmd_ready          = accept & ~pm_busy & ~erase_done;

endmodule

/* File: logic/feap_consts.vh */
// constants for the flash erase, address-mode and sleep command block
`ifndef FEAP_CONSTS_VH
`define FEAP_CONSTS_VH

// opcodes
`define FEAP_OP_ERASE_ALL_A     8'hC7
`define FEAP_OP_ERASE_ALL_B     8'h60
`define FEAP_OP_WIDE_ENTER      8'hB7
`define FEAP_OP_WIDE_EXIT       8'hE9
`define FEAP_OP_UPPER_READ      8'hC8
`define FEAP_OP_UPPER_WRITE     8'hC5
`define FEAP_OP_SLEEP           8'hB9
`define FEAP_OP_WAKE_IDENTIFY   8'hAB
`define FEAP_OP_WRITE_ENABLE    8'h06
`define FEAP_OP_WRITE_DISABLE   8'h04

// frame positions, in link clock rising edges since chip select fell
`define FEAP_OPCODE_BITS        5'h08
`define FEAP_OPCODE_LAST        5'h07
`define FEAP_DATA_LAST          5'h0F
`define FEAP_BITCNT_MAX         5'h1F

// reset value and erased byte value
`define FEAP_UPPER_RESET        8'h00
`define FEAP_ERASED_BYTE        8'hFF

// timing; system clock rate in MHz
`define FEAP_SYS_CLK_MHZ        20
// sleep entry delay, longest time, ns -> round down, at least one cycle
`define FEAP_SLEEP_ENTRY_NS     3000
`define FEAP_SLEEP_ENTRY_CYC    ((`FEAP_SLEEP_ENTRY_NS * `FEAP_SYS_CLK_MHZ) / 1000)
// wake-up delay, least time, ns -> round up
`define FEAP_WAKE_NS            3000
`define FEAP_WAKE_CYC           ((`FEAP_WAKE_NS * `FEAP_SYS_CLK_MHZ + 999) / 1000)
// whole-array erase time in ms (default of a top-level parameter)
`define FEAP_ERASE_ALL_MS       200
`define FEAP_TIMER_W            32

`endif

/* File: logic/feap_sync.v */
// two-flop synchroniser for one level from outside the system clock domain
`timescale 1ns/1ps
module feap_sync #(
   parameter RESET_VAL = 1'b0
) (
   // clock and reset
   input  wire i_clk,
   input  wire i_resetn,
   // asynchronous level in, synchronised level out
   input  wire i_async,
   output wire o_sync
);

   reg meta_reg;
   reg sync_reg;

   // first flop feeds only the second one
   always @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         meta_reg <= RESET_VAL;
         sync_reg <= RESET_VAL;
      end else begin
         meta_reg <= i_async;
         sync_reg <= meta_reg;
      end
   end

   assign o_sync = sync_reg;

endmodule

/* File: logic/feap_timer.v */
// loadable down-counter for self-timed operations with a done pulse
`timescale 1ns/1ps
`include "feap_consts.vh"
module feap_timer #(
   parameter W = `FEAP_TIMER_W
) (
   // clock and reset
   input  wire         i_clk,
   input  wire         i_resetn,
   // control
   input  wire         i_start,
   input  wire [W-1:0] i_load,
   input  wire         i_abort,
   // status
   output wire         o_busy,
   output wire         o_done
);

   reg [W-1:0] count_reg;
   reg         done_reg;

   // abort beats start so a reset always leaves the timer idle
   always @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         count_reg <= {W{1'b0}};
         done_reg  <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         if (i_abort) begin
            count_reg <= {W{1'b0}};
         end else if (i_start) begin
            count_reg <= i_load;
         end else if (count_reg != {W{1'b0}}) begin
            count_reg <= count_reg - {{(W-1){1'b0}}, 1'b1};
            if (count_reg == {{(W-1){1'b0}}, 1'b1}) begin
               done_reg <= 1'b1;
            end
         end
      end
   end

   assign o_busy = (count_reg != {W{1'b0}});
   assign o_done = done_reg;

endmodule

/* File: sim/feap_ctrl_sva.sv */
// concurrent checks on the ports of the erase, address-mode and sleep command block
`timescale 1ns/1ps
module feap_ctrl_sva #(
   parameter int ERASE_CYCLES = 50
) (
   // clock and reset
   input wire       i_sys_clk,
   input wire       i_resetn,
   // serial link
   input wire       i_spi_clk,
   input wire       i_spi_cs_n,
   input wire       i_serial_in,
   input wire       o_serial_out,
   input wire       o_serial_out_oe,
   // neighbouring logic
   input wire       i_sw_reset,
   input wire       i_any_block_protected,
   input wire       i_addr_top_valid,
   input wire [7:0] i_addr_top,
   // status and array control
   input wire       o_write_in_progress,
   input wire       o_write_enable_latch,
   input wire       o_wide_address_flag,
   input wire [7:0] o_upper_address,
   input wire [7:0] o_access_addr_hi,
   input wire       o_erase_start,
   input wire [7:0] o_erase_fill,
   input wire       o_deep_sleep,
   input wire       o_cmd_ready
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_resetn);

   ////////////////////////////////////////////////////////////////////////////////
   // length of the busy window; a counter because the erase outlasts any repetition
   logic [31:0] wip_cnt_reg;
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         wip_cnt_reg <= 32'h0000_0000;
      end else begin
         wip_cnt_reg <= o_write_in_progress ? wip_cnt_reg + 32'h0000_0001 : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   chk_fill_value: assert property (o_erase_fill == 8'hFF)
      else $error("erased byte value is not all ones");
   chk_erase_effects: assert property (o_erase_start |-> !o_write_enable_latch ##1 o_write_in_progress)
      else $error("erase start without busy or with latch still set");
   chk_erase_latch: assert property (o_erase_start |-> $past(o_write_enable_latch))
      else $error("erase started without write enable");
   chk_erase_protect: assert property (o_erase_start |-> !$past(i_any_block_protected))
      else $error("erase started while a block is protected");
   chk_erase_idle: assert property (o_erase_start |-> !$past(o_write_in_progress))
      else $error("erase restarted while busy");
   chk_busy_awake: assert property (o_write_in_progress |-> !o_deep_sleep)
      else $error("sleep entered during erase");
   chk_top_capture: assert property (i_addr_top_valid && o_wide_address_flag && !i_sw_reset
      |=> o_upper_address == $past(i_addr_top))
      else $error("wide address top byte not captured");
   chk_addr_mux: assert property (o_access_addr_hi ==
      (o_wide_address_flag ? i_addr_top : o_upper_address))
      else $error("access high byte from wrong source");
   chk_sw_reset: assert property (i_sw_reset |=>
      o_upper_address == 8'h00 && !o_wide_address_flag && !o_deep_sleep)
      else $error("software reset did not clear state");
   chk_sleep_ready: assert property (o_deep_sleep |-> !o_cmd_ready && !o_erase_start)
      else $error("commands accepted while asleep");
   chk_erase_max: assert property (wip_cnt_reg <= ERASE_CYCLES + 1)
      else $error("erase busy too long");
   chk_erase_min: assert property ($fell(o_write_in_progress) && !$past(i_sw_reset)
      |-> $past(wip_cnt_reg) >= ERASE_CYCLES - 1)
      else $error("erase busy too short");
endmodule

bind feap_ctrl feap_ctrl_sva #(.ERASE_CYCLES(ERASE_CYCLES)) u_sva (
   .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_spi_clk(i_spi_clk),
   .i_spi_cs_n(i_spi_cs_n), .i_serial_in(i_serial_in), .o_serial_out(o_serial_out),
   .o_serial_out_oe(o_serial_out_oe), .i_sw_reset(i_sw_reset),
   .i_any_block_protected(i_any_block_protected), .i_addr_top_valid(i_addr_top_valid),
   .i_addr_top(i_addr_top), .o_write_in_progress(o_write_in_progress),
   .o_write_enable_latch(o_write_enable_latch), .o_wide_address_flag(o_wide_address_flag),
   .o_upper_address(o_upper_address), .o_access_addr_hi(o_access_addr_hi),
   .o_erase_start(o_erase_start), .o_erase_fill(o_erase_fill),
   .o_deep_sleep(o_deep_sleep), .o_cmd_ready(o_cmd_ready)
);

/* File: sim/feap_host_model.sv */
// serial link host: frames commands, drives link clock, samples read data
`timescale 1ns/1ps
module feap_host_model (
   // system clock used only as a time base
   input  wire  i_sys_clk,
   // link pins
   input  wire  i_serial_out,
   output logic o_spi_clk,
   output logic o_spi_cs_n,
   output logic o_serial_in
);
   initial begin
      o_spi_clk = 1'b0;
      o_spi_cs_n = 1'b1;
      o_serial_in = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // every change lands a fixed 1 ns after a system edge to stay off the sample point
   task automatic tick(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask

   // one frame, msb first; four system cycles per link phase gives a 400 ns period
   task automatic xfer(input logic [15:0] data, input int nbits, output logic [7:0] rd);
      rd = 8'h00;
      tick(1);
      o_spi_cs_n = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         o_serial_in = data[15-i];
         tick(4);
         o_spi_clk = 1'b1;
         tick(4);
         // sampled late in the high phase: the device output lags its falling edge
         if (i >= 8 && i < 16) rd = {rd[6:0], i_serial_out};
         o_spi_clk = 1'b0;
      end
      tick(4);
      o_spi_cs_n = 1'b1;
      o_serial_in = ~o_serial_in; // released line must not keep its last value
      tick(8);
   endtask
endmodule

/* File: sim/feap_ctrl_tb_top.sv */
// top-level testbench for the erase, address-mode and sleep command block
`timescale 1ns/1ps
`include "feap_consts.vh"
module feap_ctrl_tb_top;
   logic       sys_clk;
   logic       i_resetn;
   logic       i_sw_reset;
   logic       i_any_block_protected;
   logic       i_addr_top_valid;
   logic [7:0] i_addr_top;
   wire        spi_clk, spi_cs_n, serial_in, serial_out;
   wire        write_in_progress, latch, wide, deep, ready, erase_start;
   wire        oe, so_line;
   wire [7:0]  upper, acc_hi, fill;
   logic [7:0] rd;
   int         num_errors = 0;
   int         tests_run = 0;
   int         starts = 0;
   int         cycles = 0;

   ////////////////////////////////////////////////////////////////////////////////
   // short erase keeps the run small; all erase timing below derives from 200
   feap_ctrl #(.ERASE_CYCLES(200)) DUT (
      .i_sys_clk(sys_clk), .i_resetn(i_resetn), .i_spi_clk(spi_clk),
      .i_spi_cs_n(spi_cs_n), .i_serial_in(serial_in), .o_serial_out(serial_out),
      .o_serial_out_oe(oe), .i_sw_reset(i_sw_reset),
      .i_any_block_protected(i_any_block_protected), .i_addr_top_valid(i_addr_top_valid),
      .i_addr_top(i_addr_top), .o_write_in_progress(write_in_progress), .o_write_enable_latch(latch),
      .o_wide_address_flag(wide), .o_upper_address(upper), .o_access_addr_hi(acc_hi),
      .o_erase_start(erase_start), .o_erase_fill(fill), .o_deep_sleep(deep),
      .o_cmd_ready(ready)
   );
   // an undriven output shows the inverse of its last bit, so sampling it undriven fails
   assign so_line = oe ? serial_out : ~serial_out;
   feap_host_model host (
      .i_sys_clk(sys_clk), .i_serial_out(so_line), .o_spi_clk(spi_clk),
      .o_spi_cs_n(spi_cs_n), .o_serial_in(serial_in)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // clock, erase start counter and hang guard
   always #25 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (erase_start === 1'b1) starts++;
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         close_out();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic cmd(input logic [7:0] op, input int nbits);
      host.xfer({op, 8'h00}, nbits, rd);
   endtask

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      i_resetn = 1'b0;
      i_sw_reset = 1'b0;
      i_any_block_protected = 1'b0;
      i_addr_top_valid = 1'b0;
      i_addr_top = 8'h5A;
      host.tick(3);
      i_resetn = 1'b1;
      host.tick(2);
      check(upper, 8'h00);
      check(wide, 1'b0);
      check({deep, ready, write_in_progress}, 3'b010);
      check(acc_hi, 8'h00);
      check(fill, 8'hFF);
      host.xfer({`FEAP_OP_UPPER_READ, 8'h00}, 16, rd);
      check(rd, 8'h00);
      check(oe, 1'b0);
      // upper byte write refused, then accepted once enabled
      host.xfer({`FEAP_OP_UPPER_WRITE, 8'hA5}, 16, rd);
      check(upper, 8'h00);
      cmd(`FEAP_OP_WRITE_ENABLE, 8);
      host.xfer({`FEAP_OP_UPPER_WRITE, 8'hA5}, 16, rd);
      check({latch, upper}, 9'h1A5);
      check(acc_hi, 8'hA5);
      host.xfer({`FEAP_OP_UPPER_READ, 8'h00}, 16, rd);
      check(rd, 8'hA5);
      // erase refusals: protected, wrong bit counts, no latch
      i_any_block_protected = 1'b1;
      cmd(`FEAP_OP_ERASE_ALL_A, 8);
      i_any_block_protected = 1'b0;
      check({starts[7:0], write_in_progress}, 0);
      cmd(`FEAP_OP_ERASE_ALL_A, 9);
      cmd(`FEAP_OP_ERASE_ALL_B, 7);
      check({starts[7:0], write_in_progress}, 0);
      cmd(`FEAP_OP_WRITE_DISABLE, 8);
      cmd(`FEAP_OP_ERASE_ALL_A, 8);
      check({starts[7:0], write_in_progress}, 0);
      // both erase opcodes, each with a sleep request while busy
      for (int j = 0; j < 2; j++) begin
         cmd(`FEAP_OP_WRITE_ENABLE, 8);
         cmd(j ? `FEAP_OP_ERASE_ALL_B : `FEAP_OP_ERASE_ALL_A, 8);
         check({write_in_progress, latch}, 2'b10);
         check(starts, j + 1);
         cmd(`FEAP_OP_SLEEP, 8);
         host.tick(70);
         check({deep, write_in_progress}, 2'b01);
         host.tick(60);
         check({deep, write_in_progress}, 2'b00);
      end
      // address mode, with a long frame discarded on entry and a short one on exit
      cmd(`FEAP_OP_WIDE_ENTER, 9);
      check(wide, 1'b0);
      cmd(`FEAP_OP_WIDE_ENTER, 8);
      check(wide, 1'b1);
      i_addr_top = 8'h3C;
      i_addr_top_valid = 1'b1;
      host.tick(1);
      i_addr_top_valid = 1'b0;
      i_addr_top = 8'h77;
      host.tick(1);
      check({upper, acc_hi}, 16'h3C77);
      cmd(`FEAP_OP_WIDE_EXIT, 7);
      check(wide, 1'b1);
      cmd(`FEAP_OP_WIDE_EXIT, 8);
      check({wide, acc_hi}, 9'h03C);
      host.xfer({`FEAP_OP_UPPER_READ, 8'h00}, 16, rd);
      check(rd, 8'h3C);
      // sleep entry timing, refusals while asleep, wake-up
      cmd(`FEAP_OP_SLEEP, 9);
      host.tick(70);
      check(deep, 1'b0);
      cmd(`FEAP_OP_SLEEP, 8);
      host.tick(50);
      check(deep, 1'b0);
      host.tick(10);
      check({deep, ready}, 2'b10);
      cmd(`FEAP_OP_WRITE_ENABLE, 8);
      cmd(`FEAP_OP_WIDE_ENTER, 8);
      check({latch, wide, deep}, 3'b001);
      cmd(`FEAP_OP_WAKE_IDENTIFY, 8);
      check({deep, ready}, 2'b00);
      host.tick(60);
      check(ready, 1'b1);
      // software reset leaves sleep and clears the upper byte
      cmd(`FEAP_OP_SLEEP, 8);
      host.tick(60);
      i_sw_reset = 1'b1;
      host.tick(1);
      i_sw_reset = 1'b0;
      host.tick(1);
      check({deep, upper}, 9'h000);
      close_out();
   end
endmodule
